/* verilog/rcr_pkg.sv */
// Package for the reset-cause status register block: offsets, fields, reset values and types.
package rcr_pkg;

	// Register byte offsets on the AXI4-Lite slave.
	localparam logic [3:0] RCR_OFF_CAUSE = 4'h0;
	localparam logic [3:0] RCR_OFF_IRQ_STAT = 4'h4;
	localparam logic [3:0] RCR_OFF_IRQ_MASK = 4'h8;

	// Bit positions inside the cause register.
	localparam int RCR_BIT_TRAP = 15;
	localparam int RCR_BIT_ILLEGAL = 14;
	localparam int RCR_BIT_CFG_MISMATCH = 9;
	localparam int RCR_BIT_BIAS_KEEP = 8;
	localparam int RCR_BIT_PIN_CLEAR = 7;
	localparam int RCR_BIT_SOFT = 6;
	localparam int RCR_BIT_WDT_EN = 5;
	localparam int RCR_BIT_WDT_EXP = 4;
	localparam int RCR_BIT_SLEEP = 3;
	localparam int RCR_BIT_IDLE = 2;
	localparam int RCR_BIT_BROWNOUT = 1;
	localparam int RCR_BIT_POWER_ON = 0;

	// Implemented bits (13:10 are absent) and the power-on value.
	localparam logic [15:0] RCR_IMPL_MASK = 16'hC3FF;
	localparam logic [15:0] RCR_POR_VALUE = 16'h0003;
	// Bits that hardware may set; bits 8 and 5 are software controls only.
	localparam logic [15:0] RCR_HW_SET_MASK = 16'hC2DF;

	// AXI4-Lite responses.
	localparam logic [1:0] RCR_RESP_OKAY = 2'h0;
	localparam logic [1:0] RCR_RESP_SLVERR = 2'h2;

	// Hardware events, one pulse per cause.
	typedef struct packed {
		logic trap_conflict;
		logic illegal_op;
		logic cfg_mismatch;
		logic pin_clear;
		logic soft_reset;
		logic wdt_expiry;
		logic sleep_entry;
		logic idle_entry;
		logic brownout;
	} rcr_events_t;

endpackage

/* verilog/rcr_top.sv */
// Reset-cause status register with AXI4-Lite slave and event interrupt.
//////////////////////////////////////////////////////////////////////////////
// What this block does
// - A trap conflict reset sets bit 15; power-on reset clears it and other resets leave it alone.
// - A configuration mismatch reset sets bit 9, which otherwise only a software write to the cause register sets.
// - A reset instruction that resets the device sets bit 6.
// - Bit 5 enables the watchdog, is never set by hardware and resets to zero.
// - A watchdog expiry sets bit 4.
// - Having been in sleep sets bit 3.
// - Having been in idle sets bit 2.
// - Bit 1 is set by brown-out and by power-on reset and resets to one.
// - Bit 0 is set by every power-on reset and resets to one.
// - Each reset source sets its own cause flag.
// - Power-on reset clears all flags except bits 1:0, which it sets.
//////////////////////////////////////////////////////////////////////////////
//
// Chosen here: the register offsets and the AXI4-Lite register port.
module rcr_top (
	// Clock and power-on reset
	input wire logic CLK_SYS_IN,
	input wire logic SYS_RST_IN,
	// Hardware cause events, one-cycle pulses
	input wire rcr_pkg::rcr_events_t EVENTS_IN,
	// AXI4-Lite write address and data
	input wire logic [3:0] AWADDR_IN,
	input wire logic AWVALID_IN,
	output logic AWREADY_OUT,
	input wire logic [31:0] WDATA_IN,
	input wire logic [3:0] WSTRB_IN,
	input wire logic WVALID_IN,
	output logic WREADY_OUT,
	// AXI4-Lite write response
	output logic [1:0] BRESP_OUT,
	output logic BVALID_OUT,
	input wire logic BREADY_IN,
	// AXI4-Lite read
	input wire logic [3:0] ARADDR_IN,
	input wire logic ARVALID_IN,
	output logic ARREADY_OUT,
	output logic [31:0] RDATA_OUT,
	output logic [1:0] RRESP_OUT,
	output logic RVALID_OUT,
	input wire logic RREADY_IN,
	// Controls and interrupt
	output logic WDT_ENABLE_OUT,
	output logic FLASH_BIAS_KEEP_OUT,
	output logic IRQ_OUT
);
	import rcr_pkg::*;

	logic [15:0] cause_reg;
	logic [15:0] irq_stat_reg;
	logic [15:0] irq_mask_reg;
	logic [3:0] awaddr_reg;
	logic aw_held_reg;
	logic [31:0] wdata_reg;
	logic [3:0] wstrb_reg;
	logic w_held_reg;
	logic bvalid_reg;
	logic [1:0] bresp_reg;
	logic rvalid_reg;
	logic [31:0] rdata_reg;
	logic [1:0] rresp_reg;
	logic [15:0] hw_set;
	logic wr_fire;
	logic rd_fire;
	logic [15:0] wr_bits;
	logic [15:0] wr_lanes;

	// Maps an address onto a register index; 3 means unmapped.
	function automatic logic [1:0] reg_sel(input logic [3:0] addr);
		unique case (addr)
			RCR_OFF_CAUSE: reg_sel = 2'h0;
			RCR_OFF_IRQ_STAT: reg_sel = 2'h1;
			RCR_OFF_IRQ_MASK: reg_sel = 2'h2;
			default: reg_sel = 2'h3;
		endcase
	endfunction

	//////////////////////////////////////////////////////////////////////////
	// Event decode to cause bits.
	always_comb begin
		hw_set = 16'h0000;
		hw_set[RCR_BIT_TRAP] = EVENTS_IN.trap_conflict;
		hw_set[RCR_BIT_ILLEGAL] = EVENTS_IN.illegal_op;
		hw_set[RCR_BIT_CFG_MISMATCH] = EVENTS_IN.cfg_mismatch;
		hw_set[RCR_BIT_PIN_CLEAR] = EVENTS_IN.pin_clear;
		hw_set[RCR_BIT_SOFT] = EVENTS_IN.soft_reset;
		hw_set[RCR_BIT_WDT_EXP] = EVENTS_IN.wdt_expiry;
		hw_set[RCR_BIT_SLEEP] = EVENTS_IN.sleep_entry;
		hw_set[RCR_BIT_IDLE] = EVENTS_IN.idle_entry;
		hw_set[RCR_BIT_BROWNOUT] = EVENTS_IN.brownout;
		hw_set = hw_set & RCR_HW_SET_MASK;
	end

	//////////////////////////////////////////////////////////////////////////
	// Write channel: address and data are latched independently.
	assign AWREADY_OUT = !aw_held_reg && !bvalid_reg;
	assign WREADY_OUT = !w_held_reg && !bvalid_reg;
	assign wr_fire = aw_held_reg && w_held_reg && !bvalid_reg;
	assign wr_lanes = {{8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};
	assign wr_bits = (wdata_reg[15:0] & wr_lanes) | (cause_reg & ~wr_lanes);

	always_ff @(posedge CLK_SYS_IN) begin
		if (SYS_RST_IN) begin
			aw_held_reg <= 1'b0;
			awaddr_reg <= 4'h0;
		end else if (AWVALID_IN && AWREADY_OUT) begin
			aw_held_reg <= 1'b1;
			awaddr_reg <= AWADDR_IN;
		end else if (wr_fire) begin
			aw_held_reg <= 1'b0;
		end
	end

	always_ff @(posedge CLK_SYS_IN) begin
		if (SYS_RST_IN) begin
			w_held_reg <= 1'b0;
			wdata_reg <= 32'h0000_0000;
			wstrb_reg <= 4'h0;
		end else if (WVALID_IN && WREADY_OUT) begin
			w_held_reg <= 1'b1;
			wdata_reg <= WDATA_IN;
			wstrb_reg <= WSTRB_IN;
		end else if (wr_fire) begin
			w_held_reg <= 1'b0;
		end
	end

	always_ff @(posedge CLK_SYS_IN) begin
		if (SYS_RST_IN) begin
			bvalid_reg <= 1'b0;
			bresp_reg <= RCR_RESP_OKAY;
		end else if (wr_fire) begin
			bvalid_reg <= 1'b1;
			bresp_reg <= (reg_sel(awaddr_reg) == 2'h3) ? RCR_RESP_SLVERR : RCR_RESP_OKAY;
		end else if (BREADY_IN) begin
			bvalid_reg <= 1'b0;
		end
	end

	assign BVALID_OUT = bvalid_reg;
	assign BRESP_OUT = bresp_reg;

	//////////////////////////////////////////////////////////////////////////
	// Cause register. Hardware set wins over a software clear in the same
	// cycle, so a cause landing during a write is never lost. The register
	// records causes, and bits 5 and 8 drive WDT_ENABLE_OUT and FLASH_BIAS_KEEP_OUT; nothing here feeds back into the reset tree.
	always_ff @(posedge CLK_SYS_IN) begin
		if (SYS_RST_IN) begin
			cause_reg <= RCR_POR_VALUE;
		end else if (wr_fire && reg_sel(awaddr_reg) == 2'h0) begin
			cause_reg <= (wr_bits | hw_set) & RCR_IMPL_MASK;
		end else begin
			cause_reg <= cause_reg | hw_set;
		end
	end

	assign WDT_ENABLE_OUT = cause_reg[RCR_BIT_WDT_EN];
	assign FLASH_BIAS_KEEP_OUT = cause_reg[RCR_BIT_BIAS_KEEP];

	//////////////////////////////////////////////////////////////////////////
	// Interrupt status: sticky, cleared by reading it; a new event wins.
	always_ff @(posedge CLK_SYS_IN) begin
		if (SYS_RST_IN) begin
			irq_stat_reg <= 16'h0000;
		end else if (rd_fire && reg_sel(ARADDR_IN) == 2'h1) begin
			irq_stat_reg <= hw_set;
		end else begin
			irq_stat_reg <= irq_stat_reg | hw_set;
		end
	end

	always_ff @(posedge CLK_SYS_IN) begin
		if (SYS_RST_IN) begin
			irq_mask_reg <= 16'h0000;
		end else if (wr_fire && reg_sel(awaddr_reg) == 2'h2) begin
			irq_mask_reg <= ((wdata_reg[15:0] & wr_lanes) | (irq_mask_reg & ~wr_lanes))
				& RCR_HW_SET_MASK;
		end
	end

	assign IRQ_OUT = |(irq_stat_reg & irq_mask_reg);

	//////////////////////////////////////////////////////////////////////////
	// Read channel: one cycle from address to data.
	assign ARREADY_OUT = !rvalid_reg;
	assign rd_fire = ARVALID_IN && ARREADY_OUT;

	always_ff @(posedge CLK_SYS_IN) begin
		if (SYS_RST_IN) begin
			rvalid_reg <= 1'b0;
			rdata_reg <= 32'h0000_0000;
			rresp_reg <= RCR_RESP_OKAY;
		end else if (rd_fire) begin
			rvalid_reg <= 1'b1;
			rresp_reg <= RCR_RESP_OKAY;
			unique case (reg_sel(ARADDR_IN))
				2'h0: rdata_reg <= {16'h0000, cause_reg};
				2'h1: rdata_reg <= {16'h0000, irq_stat_reg};
				2'h2: rdata_reg <= {16'h0000, irq_mask_reg};
				2'h3: begin
					rdata_reg <= 32'h0000_0000;
					rresp_reg <= RCR_RESP_SLVERR;
				end
			endcase
		end else if (RREADY_IN) begin
			rvalid_reg <= 1'b0;
		end
	end

	assign RVALID_OUT = rvalid_reg;
	assign RDATA_OUT = rdata_reg;
	assign RRESP_OUT = rresp_reg;

endmodule

/* bench/rcr_src_model.sv */
// Model of the internal reset and power-save sources that pulse the cause events.
module rcr_src_model
	import rcr_pkg::*;
(
	// Clock and requests
	input wire logic clk_in,
	input wire logic [8:0] fire_in,
	// Event pulses
	output rcr_events_t events_out
);
	// Events only leave a register, so a request never shows up mid-cycle.
	always_ff @(posedge clk_in) begin
		events_out <= rcr_events_t'(fire_in);
	end
endmodule

/* bench/rcr_checker.sv */
// Concurrent checks on the bus and control ports of the reset-cause register.
module rcr_checker
	import rcr_pkg::*;
(
	// Clock and reset
	input wire logic CLK_SYS_IN,
	input wire logic SYS_RST_IN,
	// Bus ports
	input wire logic [1:0] BRESP_OUT,
	input wire logic BVALID_OUT,
	input wire logic BREADY_IN,
	input wire logic [3:0] ARADDR_IN,
	input wire logic ARVALID_IN,
	input wire logic ARREADY_OUT,
	input wire logic [31:0] RDATA_OUT,
	input wire logic [1:0] RRESP_OUT,
	input wire logic RVALID_OUT,
	input wire logic RREADY_IN,
	// Controls
	input wire logic WDT_ENABLE_OUT,
	input wire logic FLASH_BIAS_KEEP_OUT,
	input wire logic IRQ_OUT
);
	default clocking cb @(posedge CLK_SYS_IN);
	endclocking
	default disable iff (SYS_RST_IN);
	AST_RST_OUT: assert property ($fell(SYS_RST_IN)
		|-> !(IRQ_OUT || WDT_ENABLE_OUT || FLASH_BIAS_KEEP_OUT))
		else $error("outputs not cleared by reset");
	AST_R_HOLD: assert property (RVALID_OUT && !RREADY_IN
		|=> RVALID_OUT && $stable(RDATA_OUT))
		else $error("read answer dropped");
	AST_B_HOLD: assert property (BVALID_OUT && !BREADY_IN |=> BVALID_OUT && $stable(BRESP_OUT))
		else $error("write answer dropped");
	AST_AR_ANS: assert property (ARVALID_IN && ARREADY_OUT |=> RVALID_OUT)
		else $error("read not answered");
	AST_AR_BUSY: assert property (RVALID_OUT |-> !ARREADY_OUT)
		else $error("read taken while busy");
	AST_UNMAP: assert property (ARVALID_IN && ARREADY_OUT && ARADDR_IN > 4'h8
		|=> RRESP_OUT == RCR_RESP_SLVERR && RDATA_OUT == 32'h0)
		else $error("unmapped read answered");
	AST_RSV: assert property (RVALID_OUT
		|-> RDATA_OUT[31:16] == 16'h0 && RDATA_OUT[13:10] == 4'h0)
		else $error("reserved bits set");
	AST_SW_CTRL: assert property ($changed(WDT_ENABLE_OUT) || $changed(FLASH_BIAS_KEEP_OUT)
		|-> $rose(BVALID_OUT))
		else $error("control moved without write");
	CV_RD: cover property (RVALID_OUT && RREADY_IN);
	CV_WR: cover property (BVALID_OUT && BREADY_IN);
	CV_IRQ: cover property ($rose(IRQ_OUT));
endmodule
bind rcr_top rcr_checker i_rcr_checker (.CLK_SYS_IN, .SYS_RST_IN, .BRESP_OUT, .BVALID_OUT,
	.BREADY_IN, .ARADDR_IN, .ARVALID_IN, .ARREADY_OUT, .RDATA_OUT, .RRESP_OUT, .RVALID_OUT,
	.RREADY_IN, .WDT_ENABLE_OUT, .FLASH_BIAS_KEEP_OUT, .IRQ_OUT);

/* bench/tb_rcr_top.sv */
// Self-checking bench of the reset-cause register over AXI4-Lite.
`define CHK(a, e) begin \
	samples_checked++; \
	if ((a) !== (e)) begin \
		n_errors++; \
		$display("unexpected at %0t: %h not %h", $time, a, e); \
	end \
end
module tb_rcr_top;
	timeunit 1ns;
	timeprecision 1ps;
	import rcr_pkg::*;
	logic clk = 0, rst = 1, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
	logic [3:0] awa = 0, ara = 0;
	logic [31:0] wd = 0, rd, r_d;
	logic [8:0] fire = 0;
	logic [1:0] rs, b_r, r_r;
	logic aw_rdy, w_rdy, b_v, ar_rdy, r_v, wdt, bias, irq;
	rcr_events_t ev;
	int n_errors = 0, samples_checked = 0, cyc = 0;
	int eb[9] = '{15, 14, 9, 7, 6, 4, 3, 2, 1};
	rcr_src_model i_rcr_src_model (.clk_in(clk), .fire_in(fire), .events_out(ev));
	rcr_top i_rcr_top (.CLK_SYS_IN(clk), .SYS_RST_IN(rst), .EVENTS_IN(ev), .AWADDR_IN(awa),
		.AWVALID_IN(awv), .AWREADY_OUT(aw_rdy), .WDATA_IN(wd), .WSTRB_IN(4'hF), .WVALID_IN(wv),
		.WREADY_OUT(w_rdy), .BRESP_OUT(b_r), .BVALID_OUT(b_v), .BREADY_IN(bry), .ARADDR_IN(ara),
		.ARVALID_IN(arv), .ARREADY_OUT(ar_rdy), .RDATA_OUT(r_d), .RRESP_OUT(r_r), .RVALID_OUT(r_v),
		.RREADY_IN(rry), .WDT_ENABLE_OUT(wdt), .FLASH_BIAS_KEEP_OUT(bias), .IRQ_OUT(irq));
	initial forever #5 clk = ~clk;
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		awa <= a;
		wd <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		bry <= 1'b1;
		do begin
			@(posedge clk);
			if (aw_rdy) awv <= 1'b0;
			if (w_rdy) wv <= 1'b0;
		end while (!b_v);
		rs = b_r;
		bry <= 1'b0;
	endtask
	task automatic rdr(input logic [3:0] a);
		ara <= a;
		arv <= 1'b1;
		rry <= 1'b1;
		do @(posedge clk); while (!ar_rdy);
		arv <= 1'b0;
		do @(posedge clk); while (!r_v);
		rd = r_d;
		rs = r_r;
		rry <= 1'b0;
	endtask
	// The model needs one edge to launch the pulse and the register one more to take it.
	task automatic pulse(input int i);
		fire <= 9'h100 >> i;
		@(posedge clk);
		fire <= 9'h000;
		repeat (2) @(posedge clk);
	endtask
	task automatic conclude();
		$display("errors %0d checks %0d", n_errors, samples_checked);
		if (n_errors == 0 && samples_checked > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task automatic t_events();
		for (int i = 0; i < 9; i++) begin
			wr(RCR_OFF_CAUSE, 32'h0);
			pulse(i);
			rdr(RCR_OFF_CAUSE);
			`CHK(rd, 32'h1 << eb[i])
		end
	endtask
	task automatic t_soft();
		wr(RCR_OFF_CAUSE, 32'hFFFF);
		rdr(RCR_OFF_CAUSE);
		`CHK(rd, 32'hC3FF)
		`CHK({wdt, bias}, 2'b11)
		wr(RCR_OFF_CAUSE, 32'h0);
		`CHK({wdt, bias}, 2'b00)
	endtask
	task automatic t_irq();
		rdr(RCR_OFF_IRQ_STAT);
		wr(RCR_OFF_IRQ_MASK, 32'h0010);
		`CHK(irq, 1'b0)
		pulse(5);
		`CHK(irq, 1'b1)
		rdr(RCR_OFF_IRQ_STAT);
		`CHK(rd, 32'h0010)
		`CHK(irq, 1'b0)
	endtask
	task automatic t_misc();
		wr(4'hC, 32'hFFFF);
		`CHK(rs, RCR_RESP_SLVERR)
		rdr(4'hC);
		`CHK({rd, rs}, {32'h0, RCR_RESP_SLVERR})
		wr(RCR_OFF_CAUSE, 32'hC3FC);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		rdr(RCR_OFF_CAUSE);
		`CHK(rd, 32'h0003)
		`CHK({wdt, bias, irq}, 3'b000)
	endtask
	initial begin
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		rdr(RCR_OFF_CAUSE);
		`CHK(rd, 32'h0003)
		t_events();
		t_soft();
		t_irq();
		t_misc();
		conclude();
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			n_errors++;
			conclude();
		end
	end
endmodule
